// ===== hdl/nvm_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module nvm_fifo #(
  parameter int W  = 24,
  parameter int D  = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_s;
  fifo_s         st_ff;
  fifo_s         nxt_st;
  logic [W-1:0]  buf_q [D];
  logic          full;
  logic          empty;

  assign empty     = st_ff.wp == st_ff.rp;
  assign full      = (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]) && !empty;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = buf_q[st_ff.rp[AW-1:0]];

  always_comb begin
    nxt_st = st_ff;
    if (in_valid && !full) begin
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
    if (in_valid && !full) begin
      buf_q[st_ff.wp[AW-1:0]] <= in_data;
    end
  end
endmodule

// ===== hdl/nvm_mem.sv
// Single-port memory with registered read data
`timescale 1ns/1ps
module nvm_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          core_clk,
  // Access
  input  wire logic [AW-1:0] addr,
  input  wire logic          we,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ===== hdl/nvm_prog_pkg.sv
// Constants and types shared by the parallel programming port
package nvm_prog_pkg;
  // Command bytes
  localparam logic [7:0] CMD_NOP        = 8'h00;
  localparam logic [7:0] CMD_ERASE      = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
  localparam logic [7:0] CMD_WR_EE      = 8'h11;
  localparam logic [7:0] CMD_RD_SIG     = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE    = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH   = 8'h02;
  localparam logic [7:0] CMD_RD_EE      = 8'h03;
  // Action select codes
  localparam logic [1:0] ACT_ADDR       = 2'h0;
  localparam logic [1:0] ACT_DATA       = 2'h1;
  localparam logic [1:0] ACT_CMD        = 2'h2;
  // Array geometry (flash in words, EEPROM in bytes)
  localparam int         FLASH_AW       = 16;
  localparam int         EE_AW          = 12;
  localparam int         PAGE_AW        = 7;
  localparam int         EE_PAGE_AW     = 3;
  localparam int         FIFO_DEPTH     = 16;
  localparam int         FIFO_AW        = 4;
  // Reset values of the nonvolatile bytes
  localparam logic [7:0] FUSE_LO_RST    = 8'hFF;
  localparam logic [7:0] FUSE_HI_RST    = 8'hFF;
  localparam logic [7:0] FUSE_EXT_RST   = 8'hFF;
  localparam logic [7:0] LOCK_RST       = 8'hFF;
  localparam logic [7:0] ERASED_BYTE    = 8'hFF;
  // Lock byte fields
  localparam int         LOCK_LB1       = 0;
  localparam int         LOCK_LB2       = 1;
  localparam int         LOCK_BOOT_LSB  = 2;
  localparam int         LOCK_BOOT_MSB  = 5;
  // Self-timed write durations
  localparam int         CLK_MHZ        = 10;
  localparam int         T_WRITE_US     = 10;
  localparam int         WRITE_CYC      = T_WRITE_US * CLK_MHZ;
  localparam logic [15:0] WRITE_CYC_W   = 16'(WRITE_CYC);
  // Signature and calibration (values arbitrary)
  localparam logic [7:0] SIG0           = 8'h5A;
  localparam logic [7:0] SIG1           = 8'hA5;
  localparam logic [7:0] SIG2           = 8'h3C;
  localparam logic [7:0] CAL_BYTE       = 8'h80;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FL_PROG, ST_EE_PROG, ST_ERASE, ST_NV_WRITE
  } ctl_state_e;
endpackage

// ===== hdl/nvm_prog_port.sv
// Parallel programming port for program flash, EEPROM, fuses and locks
`timescale 1ns/1ps
//
// Function
// [R1] NOP command ends page programming, clears writes
// [R2] Programmer repeats load and program per page
// [R3] EEPROM write gathers address/data bytes into page
// [R4] Write strobe commits EEPROM page, busy low
// [R5] Flash read: byte select one picks byte
// [R6] EEPROM read drives addressed byte
// [R7] Fuse low write; zero bit programs fuse
// [R8] High fuse write uses byte select one
// [R9] Extended fuse write uses byte select two
// [R10] Lock write; zero bit programs lock
// [R11] Lock mode three blocks boot lock programming
// [R12] Only chip erase clears lock bits
// [R13] Fuse/lock read selected by byte selects
// [R14] Signature command reads bytes zero to two
// [R15] Calibration byte read with byte select one
// [R16] Chip erase leaves arrays reading 0xFF
// [R17] Load strobe interprets action select pins
// [R18] Page latch copies data into page buffer
// [R19] Command and address retained across operations
// [R20] Data bus driven only for reads
module nvm_prog_port (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Strobes (load and latch are one-cycle pulses; output enable is a level)
  input  wire logic       load_strobe,
  input  wire logic       page_latch_strobe,
  input  wire logic       write_strobe_n,
  input  wire logic       output_enable_n,
  // Selects
  input  wire logic       action_select_hi,
  input  wire logic       action_select_lo,
  input  wire logic       byte_select_one,
  input  wire logic       byte_select_two,
  // Data bus
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  // Status
  output logic            ready_busy_flag,
  output logic      [7:0] lock_bits
);
  typedef struct packed {
    nvm_prog_pkg::ctl_state_e state;
    logic [7:0]  cmd;
    logic [7:0]  addr_lo;
    logic [7:0]  addr_hi;
    logic [7:0]  data_lo;
    logic [7:0]  data_hi;
    logic [7:0]  fuse_lo;
    logic [7:0]  fuse_hi;
    logic [7:0]  fuse_ext;
    logic [7:0]  lock;
    logic [15:0] timer;
    logic [16:0] erase_ptr;
    logic [nvm_prog_pkg::PAGE_AW-1:0] drain_idx;
    logic [nvm_prog_pkg::PAGE_AW:0]   page_cnt;
    logic        wr_en;
    logic [1:0]  nv_sel;
    logic [7:0]  dout;
    logic        wr_prev;
  } port_s;

  port_s st_ff;
  port_s nxt_st;

  localparam int PW = nvm_prog_pkg::PAGE_AW;
  localparam int FW = nvm_prog_pkg::FLASH_AW;
  localparam int EW = nvm_prog_pkg::EE_AW;

  // Page buffer writes go through the FIFO: {word offset, hi, lo}
  logic          fifo_in_valid;
  logic          fifo_in_ready;
  logic [22:0]   fifo_in_data;
  logic          fifo_out_valid;
  logic          fifo_out_ready;
  logic [22:0]   fifo_out_data;
  // Arrays
  logic [FW-1:0] fl_addr;
  logic          fl_we;
  logic [15:0]   fl_wdata;
  logic [15:0]   fl_rdata;
  logic [EW-1:0] ee_addr;
  logic          ee_we;
  logic [7:0]    ee_wdata;
  logic [7:0]    ee_rdata;
  logic [PW-1:0] pb_addr;
  logic          pb_we;
  logic [15:0]   pb_rdata;
  logic          wr_fall;
  logic          is_read;

  function automatic logic [1:0] act_code(input logic hi, input logic lo);
    act_code = {hi, lo};
  endfunction

  function automatic logic is_read_cmd(input logic [7:0] c);
    is_read_cmd = (c == nvm_prog_pkg::CMD_RD_FLASH) ||
                  (c == nvm_prog_pkg::CMD_RD_EE) ||
                  (c == nvm_prog_pkg::CMD_RD_FUSE) ||
                  (c == nvm_prog_pkg::CMD_RD_SIG);
  endfunction

  assign wr_fall = !write_strobe_n && st_ff.wr_prev;
  assign is_read = is_read_cmd(st_ff.cmd);

  // [R18] Page latch pushes word
  assign fifo_in_valid = page_latch_strobe && st_ff.wr_en;
  assign fifo_in_data  = {st_ff.addr_lo[PW-1:0], st_ff.data_hi,
                          st_ff.data_lo};
  // Drain only while idle so a running page program sees a stable buffer
  assign fifo_out_ready = st_ff.state == nvm_prog_pkg::ST_IDLE;

  nvm_fifo #(
    .W  (23),
    .D  (nvm_prog_pkg::FIFO_DEPTH),
    .AW (nvm_prog_pkg::FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Buffer read is registered, so its address runs one word ahead
  always_comb begin
    pb_we   = fifo_out_valid && fifo_out_ready;
    pb_addr = nxt_st.drain_idx;
    // [R3] EEPROM bytes at page offset
    if (st_ff.cmd == nvm_prog_pkg::CMD_WR_EE) begin
      pb_addr = {st_ff.addr_lo[PW-1:3], nxt_st.drain_idx[2:0]};
    end
    if (pb_we) begin
      pb_addr = fifo_out_data[22:16];
    end
  end

  nvm_mem #(.AW(PW), .DW(16)) u_pgbuf (
    .core_clk (core_clk),
    .addr     (pb_addr),
    .we       (pb_we),
    .wdata    (fifo_out_data[15:0]),
    .rdata    (pb_rdata)
  );

  nvm_mem #(.AW(FW), .DW(16)) u_flash (
    .core_clk (core_clk),
    .addr     (fl_addr),
    .we       (fl_we),
    .wdata    (fl_wdata),
    .rdata    (fl_rdata)
  );

  nvm_mem #(.AW(EW), .DW(8)) u_eeprom (
    .core_clk (core_clk),
    .addr     (ee_addr),
    .we       (ee_we),
    .wdata    (ee_wdata),
    .rdata    (ee_rdata)
  );

  // Array port steering: erase sweep, page drain, or read address
  always_comb begin
    fl_addr  = {st_ff.addr_hi, st_ff.addr_lo};
    fl_we    = 1'b0;
    fl_wdata = pb_rdata;
    ee_addr  = {st_ff.addr_hi[3:0], st_ff.addr_lo};
    ee_we    = 1'b0;
    ee_wdata = pb_rdata[7:0];
    unique case (st_ff.state)
      nvm_prog_pkg::ST_FL_PROG: begin
        fl_addr = {st_ff.addr_hi, st_ff.addr_lo[7:PW], st_ff.drain_idx};
        fl_we   = 1'b1;
      end
      nvm_prog_pkg::ST_EE_PROG: begin
        ee_addr = {st_ff.addr_hi[3:0], st_ff.addr_lo[7:3],
                   st_ff.drain_idx[2:0]};
        ee_we   = 1'b1;
      end
      nvm_prog_pkg::ST_ERASE: begin
        // [R16] Erase writes 0xFF
        fl_addr  = st_ff.erase_ptr[FW-1:0];
        fl_we    = 1'b1;
        fl_wdata = {nvm_prog_pkg::ERASED_BYTE, nvm_prog_pkg::ERASED_BYTE};
        ee_addr  = st_ff.erase_ptr[EW-1:0];
        ee_we    = 1'b1;
        ee_wdata = nvm_prog_pkg::ERASED_BYTE;
      end
      nvm_prog_pkg::ST_IDLE, nvm_prog_pkg::ST_NV_WRITE: begin
      end
    endcase
  end

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.wr_prev = write_strobe_n;
    // [R17] Action select decode
    if (load_strobe && ready_busy_flag) begin
      unique case (act_code(action_select_hi, action_select_lo))
        nvm_prog_pkg::ACT_ADDR: begin
          if (byte_select_one) begin
            nxt_st.addr_hi = data_in;
          end else begin
            nxt_st.addr_lo = data_in;
          end
        end
        nvm_prog_pkg::ACT_DATA: begin
          if (byte_select_one) begin
            nxt_st.data_hi = data_in;
          end else begin
            nxt_st.data_lo = data_in;
          end
        end
        nvm_prog_pkg::ACT_CMD: begin
          // [R19] Command held until reloaded
          nxt_st.cmd = data_in;
          // [R1] NOP clears writes
          nxt_st.wr_en = (data_in == nvm_prog_pkg::CMD_WR_FLASH) ||
                         (data_in == nvm_prog_pkg::CMD_WR_EE);
        end
        default: begin
        end
      endcase
    end
    unique case (st_ff.state)
      nvm_prog_pkg::ST_IDLE: begin
        nxt_st.drain_idx = '0;
        nxt_st.timer     = '0;
        nxt_st.erase_ptr = '0;
        if (wr_fall && !fifo_out_valid) begin
          if (st_ff.cmd == nvm_prog_pkg::CMD_WR_FLASH && st_ff.wr_en) begin
            nxt_st.state = nvm_prog_pkg::ST_FL_PROG;
          // [R4] Commit EEPROM page
          end else if (st_ff.cmd == nvm_prog_pkg::CMD_WR_EE &&
                       st_ff.wr_en && !byte_select_one) begin
            nxt_st.state = nvm_prog_pkg::ST_EE_PROG;
          end else if (st_ff.cmd == nvm_prog_pkg::CMD_ERASE) begin
            nxt_st.state = nvm_prog_pkg::ST_ERASE;
          end else if (st_ff.cmd == nvm_prog_pkg::CMD_WR_FUSE ||
                       st_ff.cmd == nvm_prog_pkg::CMD_WR_LOCK) begin
            nxt_st.nv_sel = {byte_select_two, byte_select_one};
            nxt_st.state  = nvm_prog_pkg::ST_NV_WRITE;
          end
        end
      end
      nvm_prog_pkg::ST_FL_PROG: begin
        nxt_st.drain_idx = st_ff.drain_idx + 1'b1;
        if (&st_ff.drain_idx) begin
          nxt_st.state = nvm_prog_pkg::ST_NV_WRITE;
          nxt_st.nv_sel = 2'h3;
        end
      end
      nvm_prog_pkg::ST_EE_PROG: begin
        nxt_st.drain_idx = st_ff.drain_idx + 1'b1;
        if (&st_ff.drain_idx[2:0]) begin
          nxt_st.state  = nvm_prog_pkg::ST_NV_WRITE;
          nxt_st.nv_sel = 2'h3;
        end
      end
      nvm_prog_pkg::ST_ERASE: begin
        nxt_st.erase_ptr = st_ff.erase_ptr + 1'b1;
        if (st_ff.erase_ptr[FW-1:0] == '1) begin
          // [R12] Locks cleared in the same cycle as the last array word write
          nxt_st.lock  = nvm_prog_pkg::LOCK_RST;
          nxt_st.state = nvm_prog_pkg::ST_IDLE;
        end
      end
      nvm_prog_pkg::ST_NV_WRITE: begin
        nxt_st.timer = st_ff.timer + 1'b1;
        if (st_ff.timer == nvm_prog_pkg::WRITE_CYC_W - 16'h0001) begin
          nxt_st.state = nvm_prog_pkg::ST_IDLE;
          if (st_ff.cmd == nvm_prog_pkg::CMD_WR_FUSE) begin
            // [R7] Fuse byte write
            unique case (st_ff.nv_sel)
              2'h0: nxt_st.fuse_lo  = st_ff.data_lo;
              // [R8] High fuse select
              2'h1: nxt_st.fuse_hi  = st_ff.data_lo;
              // [R9] Extended fuse select
              2'h2: nxt_st.fuse_ext = st_ff.data_lo;
              default: begin
              end
            endcase
          end else if (st_ff.cmd == nvm_prog_pkg::CMD_WR_LOCK) begin
            // [R10] [R12] Program only, never erase
            nxt_st.lock = st_ff.lock & st_ff.data_lo;
            // [R11] Boot locks frozen in mode 3
            if (!st_ff.lock[nvm_prog_pkg::LOCK_LB1] &&
                !st_ff.lock[nvm_prog_pkg::LOCK_LB2]) begin
              nxt_st.lock[nvm_prog_pkg::LOCK_BOOT_MSB:
                          nvm_prog_pkg::LOCK_BOOT_LSB] =
                st_ff.lock[nvm_prog_pkg::LOCK_BOOT_MSB:
                           nvm_prog_pkg::LOCK_BOOT_LSB];
            end
          end
        end
      end
    endcase
    // Read mux; arrays return data one cycle after address
    nxt_st.dout = 8'h00;
    unique case (st_ff.cmd)
      // [R5] Flash byte by select
      nvm_prog_pkg::CMD_RD_FLASH:
        nxt_st.dout = byte_select_one ? fl_rdata[15:8] : fl_rdata[7:0];
      // [R6] EEPROM byte
      nvm_prog_pkg::CMD_RD_EE:
        nxt_st.dout = ee_rdata;
      // [R13] Fuse and lock select
      nvm_prog_pkg::CMD_RD_FUSE: begin
        unique case ({byte_select_two, byte_select_one})
          2'h0: nxt_st.dout = st_ff.fuse_lo;
          2'h3: nxt_st.dout = st_ff.fuse_hi;
          2'h2: nxt_st.dout = st_ff.fuse_ext;
          2'h1: nxt_st.dout = st_ff.lock;
        endcase
      end
      nvm_prog_pkg::CMD_RD_SIG: begin
        // [R15] Calibration byte
        if (byte_select_one) begin
          nxt_st.dout = (st_ff.addr_lo == 8'h00) ? nvm_prog_pkg::CAL_BYTE
                                                   : 8'h00;
        // [R14] Signature bytes 0..2
        end else begin
          unique case (st_ff.addr_lo)
            8'h00:   nxt_st.dout = nvm_prog_pkg::SIG0;
            8'h01:   nxt_st.dout = nvm_prog_pkg::SIG1;
            8'h02:   nxt_st.dout = nvm_prog_pkg::SIG2;
            default: nxt_st.dout = 8'h00;
          endcase
        end
      end
      default: nxt_st.dout = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_ff          <= '0;
      st_ff.state    <= nvm_prog_pkg::ST_IDLE;
      st_ff.fuse_lo  <= nvm_prog_pkg::FUSE_LO_RST;
      st_ff.fuse_hi  <= nvm_prog_pkg::FUSE_HI_RST;
      st_ff.fuse_ext <= nvm_prog_pkg::FUSE_EXT_RST;
      st_ff.lock     <= nvm_prog_pkg::LOCK_RST;
      st_ff.wr_prev  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign data_out = st_ff.dout;
  // [R20] Drive only for reads
  assign data_oe  = !output_enable_n && is_read;
  // [R4] Busy while self-timed work runs
  assign ready_busy_flag = st_ff.state == nvm_prog_pkg::ST_IDLE &&
                           !fifo_out_valid;
  assign lock_bits = st_ff.lock;
endmodule

// ===== tb/nvm_prog_port_monitor.sv
// Checker for the parallel programming port pins
`timescale 1ns/1ps
module nvm_prog_port_monitor (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rstn,
  // Strobes and selects
  input wire logic       load_strobe,
  input wire logic       page_latch_strobe,
  input wire logic       write_strobe_n,
  input wire logic       output_enable_n,
  input wire logic       action_select_hi,
  input wire logic       action_select_lo,
  input wire logic       byte_select_one,
  input wire logic       byte_select_two,
  // Data and status
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       ready_busy_flag,
  input wire logic [7:0] lock_bits
);
  logic [7:0] cmd_ff;
  logic [7:0] alo_ff;
  logic       wrn_ff;
  logic       wr_go;
  logic       nv_go;
  logic       rd_cmd;
  logic [7:0] sig_exp;

  // Shadow of what the port took; loads while busy are dropped as well
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cmd_ff <= 8'h00;
      alo_ff <= 8'h00;
      wrn_ff <= 1'b1;
    end else begin
      wrn_ff <= write_strobe_n;
      if (load_strobe && ready_busy_flag && !action_select_lo) begin
        if (action_select_hi) begin
          cmd_ff <= data_in;
        end else if (!byte_select_one && !byte_select_two) begin
          alo_ff <= data_in;
        end
      end
    end
  end

  assign wr_go = wrn_ff && !write_strobe_n && ready_busy_flag;
  assign nv_go = wr_go && cmd_ff inside {nvm_prog_pkg::CMD_WR_FUSE,
    nvm_prog_pkg::CMD_WR_LOCK, nvm_prog_pkg::CMD_ERASE};
  assign rd_cmd = cmd_ff inside {nvm_prog_pkg::CMD_RD_FLASH,
    nvm_prog_pkg::CMD_RD_EE, nvm_prog_pkg::CMD_RD_FUSE,
    nvm_prog_pkg::CMD_RD_SIG};
  assign sig_exp = (alo_ff == 8'h00) ? nvm_prog_pkg::SIG0 :
    (alo_ff == 8'h01) ? nvm_prog_pkg::SIG1 : nvm_prog_pkg::SIG2;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_bus_drive_read: assert property (
    data_oe == (!output_enable_n && rd_cmd))
    else $error("data bus enable does not match read state");
  a_busy_on_write: assert property (
    nv_go |=> !ready_busy_flag [*8])
    else $error("no busy after self-timed write");
  a_write_done_time: assert property (
    nv_go && cmd_ff != nvm_prog_pkg::CMD_ERASE |-> ##[95:110] ready_busy_flag)
    else $error("fuse or lock write did not finish in time");
  a_ee_commit_busy: assert property (
    wr_go && !byte_select_one && cmd_ff == nvm_prog_pkg::CMD_WR_EE
    |=> !ready_busy_flag [*8])
    else $error("no busy after page commit");
  a_lock_no_undo: assert property (
    cmd_ff != nvm_prog_pkg::CMD_ERASE
    |-> (lock_bits & ~$past(lock_bits)) == 8'h00)
    else $error("lock bit returned to one without erase");
  a_boot_lock_frozen: assert property (
    $past(lock_bits[1:0]) == 2'b00 && cmd_ff != nvm_prog_pkg::CMD_ERASE
    |-> $stable(lock_bits[5:2]))
    else $error("boot lock bits changed in lock mode three");
  a_lock_readback: assert property (
    (cmd_ff == nvm_prog_pkg::CMD_RD_FUSE && byte_select_one &&
    !byte_select_two) [*3] |-> data_out == lock_bits)
    else $error("lock byte read back wrong");
  a_sig_byte_read: assert property (
    (cmd_ff == nvm_prog_pkg::CMD_RD_SIG && !byte_select_one &&
    alo_ff <= 8'h02 && $stable(alo_ff)) [*3] |-> data_out == sig_exp)
    else $error("signature byte read back wrong");

  c_ee_commit: cover property (wr_go && cmd_ff == nvm_prog_pkg::CMD_WR_EE);
  c_erase: cover property (wr_go && cmd_ff == nvm_prog_pkg::CMD_ERASE);
  c_flash_latch: cover property (page_latch_strobe &&
    cmd_ff == nvm_prog_pkg::CMD_WR_FLASH);
endmodule

bind nvm_prog_port nvm_prog_port_monitor nvm_prog_port_monitor_inst (
  .core_clk(core_clk), .rstn(rstn), .load_strobe(load_strobe),
  .page_latch_strobe(page_latch_strobe), .write_strobe_n(write_strobe_n),
  .output_enable_n(output_enable_n), .action_select_hi(action_select_hi),
  .action_select_lo(action_select_lo), .byte_select_one(byte_select_one),
  .byte_select_two(byte_select_two), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe),
  .ready_busy_flag(ready_busy_flag), .lock_bits(lock_bits)
);

// ===== tb/prog_bus_model.sv
// Programmer side of the shared data wire
`timescale 1ns/1ps
module prog_bus_model (
  // Clock
  input  wire logic       core_clk,
  // Programmer drive
  input  wire logic       drive_en,
  input  wire logic [7:0] drive_val,
  // Device drive
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  // Resolved wire
  output logic      [7:0] bus_level
);
  logic [7:0] last_ff;

  // Undriven wire toggles so a stale value can never pass as a read
  always_comb begin
    if (drive_en) begin
      bus_level = drive_val;
    end else if (data_oe) begin
      bus_level = data_out;
    end else begin
      bus_level = ~last_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    last_ff <= bus_level;
  end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the parallel programming port
`timescale 1ns/1ps
module tb;
  logic       core_clk, rstn, ld_stb, pl_stb, wr_n, oe_n;
  logic       xa_hi, xa_lo, bs1, bs2, drv_en, data_oe, rdy;
  logic [7:0] drv_val, bus, data_out, lock_bits;
  int         err_count, tests_run;

  always #50 core_clk = ~core_clk;

  nvm_prog_port nvm_prog_port_inst (
    .core_clk(core_clk), .rstn(rstn), .load_strobe(ld_stb),
    .page_latch_strobe(pl_stb), .write_strobe_n(wr_n),
    .output_enable_n(oe_n), .action_select_hi(xa_hi),
    .action_select_lo(xa_lo), .byte_select_one(bs1),
    .byte_select_two(bs2), .data_in(bus), .data_out(data_out),
    .data_oe(data_oe), .ready_busy_flag(rdy), .lock_bits(lock_bits)
  );
  prog_bus_model prog_bus_model_inst (
    .core_clk(core_clk), .drive_en(drv_en), .drive_val(drv_val),
    .data_out(data_out), .data_oe(data_oe), .bus_level(bus)
  );

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_rdy(input int lim);
    int n;
    n = 0;
    @(negedge core_clk);
    while (rdy !== 1'b1) begin
      n++;
      if (n > lim) begin
        check8({7'h00, rdy}, 8'h01);
        report_and_stop();
      end
      @(negedge core_clk);
    end
  endtask

  // Loads are refused while busy, so every load waits for ready first
  task automatic ld(input logic [1:0] act, input logic b1,
                    input logic [7:0] v);
    wait_rdy(300);
    @(posedge core_clk);
    {xa_hi, xa_lo} <= act;
    bs1 <= b1;
    drv_val <= v;
    ld_stb <= 1'b1;
    @(posedge core_clk);
    ld_stb <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] v);
    ld(nvm_prog_pkg::ACT_CMD, 1'b0, v);
  endtask

  task automatic adr(input logic b1, input logic [7:0] v);
    ld(nvm_prog_pkg::ACT_ADDR, b1, v);
  endtask

  task automatic dat(input logic b1, input logic [7:0] v);
    ld(nvm_prog_pkg::ACT_DATA, b1, v);
  endtask

  task automatic sel(input logic b1, input logic b2);
    @(posedge core_clk);
    bs1 <= b1;
    bs2 <= b2;
  endtask

  task automatic latch_pg();
    @(posedge core_clk);
    pl_stb <= 1'b1;
    @(posedge core_clk);
    pl_stb <= 1'b0;
  endtask

  task automatic wr_pulse(input int lim);
    wait_rdy(300);
    @(posedge core_clk);
    wr_n <= 1'b0;
    @(posedge core_clk);
    wr_n <= 1'b1;
    wait_rdy(lim);
  endtask

  task automatic rd(input logic b1, input logic b2, input logic [7:0] exp);
    @(posedge core_clk);
    drv_en <= 1'b0;
    oe_n <= 1'b0;
    bs1 <= b1;
    bs2 <= b2;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    check8({7'h00, data_oe}, 8'h01);
    check8(bus, exp);
    @(posedge core_clk);
    oe_n <= 1'b1;
    drv_en <= 1'b1;
  endtask

  task automatic t_fuse_lock();
    cmd(nvm_prog_pkg::CMD_WR_FUSE);
    dat(1'b0, 8'hA5);
    wr_pulse(300);
    dat(1'b0, 8'h3C);
    sel(1'b1, 1'b0);
    wr_pulse(300);
    dat(1'b0, 8'h96);
    sel(1'b0, 1'b1);
    wr_pulse(300);
    sel(1'b0, 1'b0);
    cmd(nvm_prog_pkg::CMD_RD_FUSE);
    rd(1'b0, 1'b0, 8'hA5);
    rd(1'b1, 1'b1, 8'h3C);
    rd(1'b0, 1'b1, 8'h96);
    rd(1'b1, 1'b0, nvm_prog_pkg::LOCK_RST);
    cmd(nvm_prog_pkg::CMD_WR_LOCK);
    dat(1'b0, 8'hFC);
    wr_pulse(300);
    check8(lock_bits, 8'hFC);
    dat(1'b0, 8'hC3);
    wr_pulse(300);
    check8(lock_bits, 8'hFC);
    dat(1'b0, 8'hFF);
    wr_pulse(300);
    check8(lock_bits, 8'hFC);
    $display("test fuse_lock done");
  endtask

  task automatic t_flash();
    cmd(nvm_prog_pkg::CMD_WR_FLASH);
    adr(1'b1, 8'h02);
    for (int i = 0; i < 2; i++) begin
      adr(1'b0, 8'(8'h05 + i));
      dat(1'b0, 8'(8'h21 + i));
      dat(1'b1, 8'(8'hC4 + i));
      latch_pg();
    end
    wr_pulse(400);
    cmd(nvm_prog_pkg::CMD_NOP);
    // A latch after the no-op must not reach the page buffer
    latch_pg();
    @(negedge core_clk);
    check8({7'h00, rdy}, 8'h01);
    cmd(nvm_prog_pkg::CMD_RD_FLASH);
    adr(1'b1, 8'h02);
    for (int i = 0; i < 2; i++) begin
      adr(1'b0, 8'(8'h05 + i));
      rd(1'b0, 1'b0, 8'(8'h21 + i));
      rd(1'b1, 1'b0, 8'(8'hC4 + i));
    end
    $display("test flash done");
  endtask

  task automatic t_eeprom();
    cmd(nvm_prog_pkg::CMD_WR_EE);
    @(posedge core_clk);
    oe_n <= 1'b0;
    @(negedge core_clk);
    check8({7'h00, data_oe}, 8'h00);
    @(posedge core_clk);
    oe_n <= 1'b1;
    adr(1'b1, 8'h01);
    for (int i = 0; i < 2; i++) begin
      adr(1'b0, 8'(8'h10 + i));
      dat(1'b0, 8'(8'h3A + i));
      sel(1'b1, 1'b0);
      latch_pg();
    end
    sel(1'b0, 1'b0);
    wr_pulse(300);
    cmd(nvm_prog_pkg::CMD_RD_EE);
    adr(1'b1, 8'h01);
    for (int i = 0; i < 2; i++) begin
      adr(1'b0, 8'(8'h10 + i));
      rd(1'b0, 1'b0, 8'(8'h3A + i));
    end
    $display("test eeprom done");
  endtask

  task automatic t_sig();
    logic [7:0] sig_tab [3] = '{nvm_prog_pkg::SIG0, nvm_prog_pkg::SIG1,
                                nvm_prog_pkg::SIG2};
    cmd(nvm_prog_pkg::CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      adr(1'b0, 8'(i));
      rd(1'b0, 1'b0, sig_tab[i]);
    end
    adr(1'b0, 8'h00);
    ld(2'h3, 1'b0, nvm_prog_pkg::CMD_RD_FLASH);
    rd(1'b1, 1'b0, nvm_prog_pkg::CAL_BYTE);
    @(negedge core_clk);
    check8({7'h00, data_oe}, 8'h00);
    $display("test signature done");
  endtask

  task automatic t_erase();
    cmd(nvm_prog_pkg::CMD_ERASE);
    wr_pulse(70000);
    check8(lock_bits, nvm_prog_pkg::ERASED_BYTE);
    cmd(nvm_prog_pkg::CMD_RD_FLASH);
    adr(1'b1, 8'h02);
    adr(1'b0, 8'h05);
    rd(1'b0, 1'b0, nvm_prog_pkg::ERASED_BYTE);
    rd(1'b1, 1'b0, nvm_prog_pkg::ERASED_BYTE);
    cmd(nvm_prog_pkg::CMD_RD_EE);
    adr(1'b1, 8'h01);
    adr(1'b0, 8'h10);
    rd(1'b0, 1'b0, nvm_prog_pkg::ERASED_BYTE);
    $display("test erase done");
  endtask

  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    {ld_stb, pl_stb, xa_hi, xa_lo, bs1, bs2} = '0;
    {wr_n, oe_n, drv_en} = '1;
    drv_val = 8'h00;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    t_fuse_lock();
    t_flash();
    t_eeprom();
    t_sig();
    t_erase();
    report_and_stop();
  end
endmodule
